//--- src/dcs_chain_port.sv
/*
 * daisy-chain readout port of an 18-bit converter: mode selection at the
 * strobe rise, conversion timing, result shift register, busy propagation.
 * assumes conv_result is stable from the system clock domain, and that
 * strobe, chain input and serial clock are asynchronous pins.
 */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - chain mode when chain input low at rise
// - clock low at rise selects no busy
// - clock high at rise selects busy
// - output always driven in chain mode
// - chain input and strobe low drive output low
// - no busy: MSB out at conversion end
// - shift one bit per falling clock edge
// - shift chain input in on each edge
// - busy variant: busy shown at conversion end
// - busy only when done and upstream enabled
// - busy variant: first edge not chained
module dcs_chain_port
   import dcs_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYC
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic conversion_strobe,
   input wire logic chain_data_in,
   input wire logic [RES_W-1:0] conv_result,
   output logic conv_start,
   output logic conv_busy,
   output logic chain_data_out,
   output logic chain_data_out_oe_n
);

   // ==========================================================
   // pin synchronisers
   logic [SYN_W-1:0] pins_raw;            // async pin levels
   logic [SYN_W-1:0] pins_s;              // synchronised levels
   logic strobe_s;                        // strobe, clk domain
   logic sdi_s;                           // chain input, clk domain
   logic sclk_s;                          // serial clock level
   logic strobe_q;                        // strobe one cycle back
   logic strobe_rise;                     // strobe rising edge
   logic sdi_q;                           // chain input one cycle back
   logic sclk_q;                          // serial clock one cycle back

   assign pins_raw = {sclk, chain_data_in, conversion_strobe};
   assign strobe_s = pins_s[SYN_STROBE];
   assign sdi_s = pins_s[SYN_CHAIN];
   assign sclk_s = pins_s[SYN_SCLK];
   // all three levels pass the same stages, so they stay aligned
   assign strobe_rise = strobe_s & ~strobe_q;

   dcs_sync #(.W(SYN_W)) u_pin_sync
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(pins_raw),
      .q(pins_s)
   );

   // previous levels for edge detection and for mode sampling; the
   // levels just before the rise are the ones that count, so a chain
   // input wired to the strobe still reads low at the rise
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         strobe_q <= 1'b0;
         sdi_q <= 1'b0;
         sclk_q <= 1'b0;
      end
      else
      begin
         strobe_q <= strobe_s;
         sdi_q <= sdi_s;
         sclk_q <= sclk_s;
      end
   end

   // ==========================================================
   // serial-clock domain and the pointer crossing
   dcs_edge_if lnk ();                    // capture to core carrier
   logic [CNT_W-1:0] ptr_gray_s;          // synchronised gray pointer
   logic [CNT_W-1:0] ptr_bin;             // edges seen by the link side
   logic [CNT_W-1:0] seen;                // edges consumed here
   logic edge_pend;                       // at least one edge waiting
   logic take_bit;                        // chain bit of oldest edge

   dcs_edge_capture u_cap
   (
      .sclk(sclk),
      .sys_rst(sys_rst),
      .chain_data_in(chain_data_in),
      .lnk(lnk)
   );

   dcs_sync #(.W(CNT_W)) u_ptr_sync
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(lnk.edge_gray),
      .q(ptr_gray_s)
   );

   assign ptr_bin = dcs_gray2bin(ptr_gray_s);
   assign edge_pend = (ptr_bin != seen);
   // slot is stable: written on the same edge that moved the pointer that names it
   assign take_bit = lnk.edge_bit[seen[0]];

   // ==========================================================
   // mode selection
   logic chain_mode;                      // daisy-chain interface active
   logic busy_mode;                       // busy-indicator variant

   // modes are sampled at each strobe rise and held until the next
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         chain_mode <= 1'b0;
         busy_mode <= 1'b0;
      end
      else if (strobe_rise)
      begin
         chain_mode <= ~sdi_q;
         busy_mode <= sclk_q;
      end
   end

   // ==========================================================
   // controller
   dcs_state_e state;                     // current phase
   logic [CONV_CNT_W-1:0] conv_cnt;       // cycles left in conversion
   logic conv_done;                       // last conversion cycle

   assign conv_done = (state == ST_CONV) && (conv_cnt == '0);

   // a rise restarts from any phase; an early rise cuts a readout short
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= ST_IDLE;
      end
      else if (strobe_rise)
      begin
         state <= ST_CONV;
      end
      else
      begin
         case (state)
            ST_IDLE: state <= ST_IDLE;
            ST_CONV:
            begin
               // back to acquisition once converted
               if (conv_done)
               begin
                  state <= ST_READ;
               end
            end
            ST_READ: state <= ST_READ;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // conversion timer, loaded at every rise
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         conv_cnt <= '0;
      end
      else if (strobe_rise)
      begin
         conv_cnt <= CONV_CNT_W'(CONV_CYCLES - 1);
      end
      else if (state == ST_CONV && conv_cnt != '0)
      begin
         conv_cnt <= conv_cnt - 1'b1;
      end
   end

   // user-side status
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         conv_start <= 1'b0;
         conv_busy <= 1'b0;
      end
      else
      begin
         conv_start <= strobe_rise;
         conv_busy <= strobe_rise | ((state == ST_CONV) & ~conv_done);
      end
   end

   // ==========================================================
   // result shift register
   logic [RES_W-1:0] sh;                  // result plus chained bits
   logic busy_phase;                      // busy bit still on the output

   // edges outside readout are stale and dropped, so a stray clock during
   // conversion cannot shift the result
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         seen <= '0;
      end
      else if (state == ST_READ && edge_pend)
      begin
         seen <= seen + 1'b1;
      end
      else if (state != ST_READ)
      begin
         seen <= ptr_bin;
      end
   end

   // load at conversion end, then one shift per falling edge after any busy edge
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sh <= '0;
         busy_phase <= 1'b0;
      end
      else if (conv_done)
      begin
         sh <= conv_result;
         busy_phase <= busy_mode;
      end
      else if (state == ST_READ && edge_pend)
      begin
         if (busy_phase)
         begin
            // first edge only retires the busy bit
            busy_phase <= 1'b0;
         end
         else
         begin
            sh <= {sh[RES_W-2:0], take_bit};
         end
      end
   end

   // ==========================================================
   // serial output
   logic next_dout;                       // output level next cycle

   always_comb
   begin
      next_dout = 1'b0;
      if (!strobe_s && !sdi_s)
      begin
         // arms the downstream device for chain mode
         next_dout = 1'b0;
      end
      else if (state == ST_READ)
      begin
         // busy only after own conversion, gated by upstream enable
         next_dout = busy_phase ? sdi_s : sh[RES_W-1];
      end
   end

   // output driven whenever the chain interface is selected; released
   // otherwise because the select modes belong to other logic
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         chain_data_out <= RST_DOUT;
         chain_data_out_oe_n <= RST_OE_N;
      end
      else
      begin
         chain_data_out <= next_dout;
         chain_data_out_oe_n <= ~chain_mode;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_chain_entry: assert property (strobe_rise |=> chain_mode == !$past(sdi_q))
      else $error("chain mode not taken from chain input at rise");

   a_nobusy_select: assert property (strobe_rise && !sclk_q |=> !busy_mode)
      else $error("no-busy variant not selected");

   a_busy_select: assert property (strobe_rise && sclk_q |=> busy_mode)
      else $error("busy variant not selected");

   a_output_drive: assert property (chain_mode |=> !chain_data_out_oe_n)
      else $error("output released in chain mode");

   a_output_release: assert property (!chain_mode |=> chain_data_out_oe_n)
      else $error("output driven outside chain mode");

   a_start_pulse: assert property (strobe_rise |=> conv_start && state == ST_CONV)
      else $error("strobe rise did not start a conversion");

   a_low_pass: assert property (!strobe_s && !sdi_s |=> !chain_data_out)
      else $error("output not low with strobe and chain input low");

   a_msb_first: assert property (conv_done && !busy_mode |=> ##1
      (chain_data_out == $past(conv_result[RES_W-1], 2)) || $past(!strobe_s && !sdi_s))
      else $error("msb not presented at conversion end");

   a_shift_step: assert property (state == ST_READ && edge_pend && !busy_phase
      && !conv_done |=> sh == {$past(sh[RES_W-2:0]), $past(take_bit)})
      else $error("shift register did not take chained bit");

   a_busy_gate: assert property (state == ST_CONV |=> !chain_data_out)
      else $error("busy shown before conversion done");

   // busy output only mirrors the upstream enable once converted
   a_busy_follow: assert property (state == ST_READ && busy_phase
      |=> chain_data_out == $past(sdi_s))
      else $error("busy output does not follow upstream enable");

   // readout bit on the pin is the top of the shift register
   a_data_out: assert property (state == ST_READ && !busy_phase && (strobe_s || sdi_s)
      |=> chain_data_out == $past(sh[RES_W-1]))
      else $error("serial output not the shift register top bit");

   a_busy_skip: assert property (state == ST_READ && edge_pend && busy_phase
      && !conv_done |=> !busy_phase && $stable(sh))
      else $error("first busy edge shifted data");

   a_mode_hold: assert property (!strobe_rise |=> $stable(chain_mode) && $stable(busy_mode))
      else $error("mode changed without strobe rise");

endmodule

`default_nettype wire

//--- src/dcs_pkg.sv
/*
 * shared constants and types for the daisy-chain serial readout block.
 * assumes nothing but a SystemVerilog compiler; no module depends on order
 * other than this package compiling first.
 */
package dcs_pkg;

   // ==========================================================
   // widths
   localparam int RES_W = 18;             // result word width
   localparam int CNT_W = 4;              // falling-edge pointer width
   localparam int SLOT_N = 2;             // captured-bit slots

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 8;      // system clock period
   localparam int CONV_TIME_NS = 2000;    // conversion time, plain default
   // least time, so round up to whole cycles
   localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_CNT_W = $clog2(CONV_CYC + 1);

   // ==========================================================
   // pin synchroniser bit positions
   localparam int SYN_STROBE = 0;         // conversion strobe level
   localparam int SYN_CHAIN = 1;          // chain data input level
   localparam int SYN_SCLK = 2;           // serial clock level
   localparam int SYN_W = 3;

   // ==========================================================
   // reset values
   localparam logic RST_DOUT = 1'b0;      // serial output at reset
   localparam logic RST_OE_N = 1'b1;      // output released at reset

   // ==========================================================
   // controller states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,                   // acquisition, no result pending
      ST_CONV = 3'b010,                   // converting
      ST_READ = 3'b100                    // acquisition with readout
   } dcs_state_e;

   // gray to binary for the edge pointer
   function automatic logic [CNT_W-1:0] dcs_gray2bin(input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b = g;
      for (int i = CNT_W - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

//--- src/dcs_edge_if.sv
/*
 * carrier between the serial-clock capture logic and the core.
 * assumes the pointer is gray coded and the slots change only on the edge
 * that advances it, so a reader may trust a slot once it sees the pointer.
 */
`timescale 1ns/100ps
`default_nettype none

interface dcs_edge_if;
   import dcs_pkg::*;
   logic [CNT_W-1:0] edge_gray;           // falling edges seen, gray
   logic [SLOT_N-1:0] edge_bit;           // chain input at each edge
   modport cap (output edge_gray, output edge_bit);
   modport core (input edge_gray, input edge_bit);
endinterface

`default_nettype wire

//--- src/dcs_sync.sv
/*
 * two-flop level synchroniser, any width.
 * assumes each bit is a level that holds for several destination cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module dcs_sync
   import dcs_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta;                    // first stage, read only by q

   // ==========================================================
   // two stages, nothing taps the first
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta <= '0;
         q <= '0;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

`default_nettype wire

//--- src/dcs_edge_capture.sv
/*
 * serial-clock domain: samples the chain input on each falling edge.
 * assumes the serial clock may stop between frames; nothing here needs an
 * edge outside a frame, the core discards stale edges itself.
 */
`timescale 1ns/100ps
`default_nettype none

module dcs_edge_capture
   import dcs_pkg::*;
(
   input wire logic sclk,
   input wire logic sys_rst,
   input wire logic chain_data_in,
   dcs_edge_if.cap lnk
);

   logic [CNT_W-1:0] edge_bin;            // binary edge count
   logic [CNT_W-1:0] next_bin;            // count after this edge

   assign next_bin = edge_bin + 1'b1;

   // ==========================================================
   // edge counter, published gray so one bit moves per edge
   always_ff @(negedge sclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         edge_bin <= '0;
         lnk.edge_gray <= '0;
      end
      else
      begin
         edge_bin <= next_bin;
         lnk.edge_gray <= next_bin ^ (next_bin >> 1);
      end
   end

   // ==========================================================
   // two slots: a slot is rewritten only two edges later, long after the
   // core has read it
   always_ff @(negedge sclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lnk.edge_bit <= '0;
      end
      else
      begin
         lnk.edge_bit[edge_bin[0]] <= chain_data_in;
      end
   end

endmodule

`default_nettype wire

//--- testbench/dcs_host_model.sv
/*
 * far side of the chain port: host clocking the serial clock and the
 * upstream chained device driving the chain input; host samples the pin.
 * assumes the bench computes the pin level from the output enable.
 */
`timescale 1ns/100ps
`default_nettype none

module dcs_host_model
(
   input wire logic pin,
   output logic sclk,
   output logic chain_data_in,
   output logic smp,
   output logic smp_bit
);
   // ==========================================
   // idle levels; outside frames the clock only moves to its resting level
   initial
   begin
      sclk = 1'b0;
      chain_data_in = 1'b1;
      smp = 1'b0;
      smp_bit = 1'b0;
   end

   // chain level and resting clock level before a strobe rise
   task automatic set_line(input logic din, input logic idle);
      chain_data_in = din;
      sclk = idle;
   endtask

   // host sample of the pin, flagged to the bench monitor
   task automatic probe();
      smp_bit = pin;
      smp = 1'b1;
      #1 smp = 1'b0;
   endtask

   // one readout burst; upstream bits change after each falling edge
   task automatic frame(input logic [18:0] w, input int nw, input int ne);
      chain_data_in = w[nw-1];
      for (int i = 0; i < ne; i++)
      begin
         sclk = 1'b1;
         #61.5;
         probe();
         sclk = 1'b0;
         #10;
         // past the word the line toggles, never a stale value
         chain_data_in = (i + 1 < nw) ? w[nw-2-i] : ~chain_data_in;
         #52.5;
      end
   endtask
endmodule

`default_nettype wire

//--- testbench/test_adc_daisy_chain_serial_port.sv
/*
 * self-checking bench for the chain port: conversions in every mode,
 * readout through a partner model, expectations queued and compared.
 * assumes the design package compiles first.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s expected %b seen %b", nm, e, g); end end

module test_adc_daisy_chain_serial_port;
   import dcs_pkg::*;
   // ==========================================
   // signals
   localparam int CONV_N = 8; // shortened conversion
   logic clk;
   logic sys_rst;
   logic conversion_strobe;
   logic [RES_W-1:0] conv_result;
   logic conv_start;
   logic conv_busy;
   logic chain_data_out;
   logic chain_data_out_oe_n;
   wire logic sclk;
   wire logic chain_data_in;
   wire logic smp;
   wire logic smp_bit;
   wire logic pin; // resolved output pin
   logic note[$]; // expected pin levels
   logic [31:0] rnd;
   int mismatches = 0;
   int samples_checked = 0;
   int starts = 0; // conv_start pulses seen
   int busy_cyc = 0; // cycles with conv_busy high

   assign pin = chain_data_out_oe_n ? 1'bz : chain_data_out;

   dcs_chain_port #(.CONV_CYCLES(CONV_N)) dut
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .sclk(sclk),
      .conversion_strobe(conversion_strobe),
      .chain_data_in(chain_data_in),
      .conv_result(conv_result),
      .conv_start(conv_start),
      .conv_busy(conv_busy),
      .chain_data_out(chain_data_out),
      .chain_data_out_oe_n(chain_data_out_oe_n)
   );

   dcs_host_model host
   (
      .pin(pin),
      .sclk(sclk),
      .chain_data_in(chain_data_in),
      .smp(smp),
      .smp_bit(smp_bit)
   );

   // ==========================================
   // clock and helpers
   always #4 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // inputs move just after the rising edge, same delay always
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic summarize();
      $display("samples %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // bounded wait over one whole conversion
   task automatic wait_conv();
      int n;
      n = 0;
      while (conv_busy !== 1'b1 && n < 40)
      begin
         step(1);
         n++;
      end
      while (conv_busy !== 1'b0 && n < 80)
      begin
         step(1);
         n++;
      end
      if (n >= 40)
      begin
         mismatches++;
         $display("[ERR] conv_busy expected 0 seen %b", conv_busy);
      end
   endtask

   // ==========================================
   // one conversion and its readout
   task automatic run_test(input int t, input logic chain, input logic busy);
      logic [17:0] r;
      logic [17:0] u;
      int s0;
      int b0;
      rnd = lfsr(rnd);
      r = rnd[17:0];
      rnd = lfsr(rnd);
      u = rnd[17:0];
      conversion_strobe = 1'b0;
      host.set_line(~chain, busy);
      step(8);
      // override only shows once the pin is already driven
      if (chain && t > 1)
      begin
         note.push_back(1'b0);
         host.probe();
      end
      conv_result = r;
      step(1);
      s0 = starts;
      b0 = busy_cyc;
      conversion_strobe = 1'b1;
      // last busy run: chain input wired to the strobe, rising with it
      if (busy && t == 4)
         host.set_line(1'b1, 1'b1);
      wait_conv();
      `CHK("conv_start", s0 + 1, starts)
      `CHK("conv_busy", b0 + CONV_N, busy_cyc)
      step(8);
      if (!chain)
      begin
         note.push_back(1'bz);
         host.probe();
      end
      else
      begin
         if (busy)
         begin
            // with the wired input the enable is already high here
            if (t != 4)
            begin
               note.push_back(1'b0);
               host.probe();
            end
            host.set_line(1'b1, 1'b1);
            step(8);
            note.push_back(1'b1);
         end
         for (int i = 17; i >= 0; i--)
            note.push_back(r[i]);
         for (int i = 17; i >= 0; i--)
            note.push_back(u[i]);
         host.frame({busy, u}, busy ? 19 : 18, busy ? 37 : 36);
      end
      step(4);
      $display("test %0d done, chain %b busy %b", t, chain, busy);
   endtask

   // ==========================================
   // monitor: oldest note against each host sample
   always @(posedge smp)
   begin
      logic expd;
      if (note.size() == 0)
      begin
         mismatches++;
         $display("[ERR] note queue expected 1 seen 0");
      end
      else
      begin
         // pop once: the macro names its expected value twice
         expd = note.pop_front();
         `CHK("pin", expd, smp_bit)
      end
   end

   // status outputs counted between rising edges, where they are settled
   always @(negedge clk)
   begin
      if (conv_start === 1'b1)
         starts++;
      if (conv_busy === 1'b1)
         busy_cyc++;
   end

   // ==========================================
   // main sequence
   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      conversion_strobe = 1'b0;
      conv_result = '0;
      rnd = 32'h4BD5F2B4;
      repeat (5) @(posedge clk);
      #1 sys_rst = 1'b0;
      step(4);
      `CHK("oe_n after reset", 1'b1, chain_data_out_oe_n)
      `CHK("conv_busy after reset", 1'b0, conv_busy)
      for (int t = 0; t < 6; t++)
         run_test(t, t > 0 && t < 5, t == 2 || t == 4);
      `CHK("notes left", 0, note.size())
      summarize();
   end

   // watchdog far beyond six conversions and their four readouts
   initial
   begin
      #400000;
      mismatches++;
      $display("[ERR] watchdog expected done seen hang");
      summarize();
   end
endmodule

`default_nettype wire
